// ---- design/hpss_cfg.svh ----
// Purpose: Offsets, field positions and reset values of the slot status bank.
// Assumes: Register indices times four give the byte address.
// Notes: Included by the tracker and slot status design files and the bench; the package and interface do not include it.
`ifndef HPSS_CFG_SVH
`define HPSS_CFG_SVH
// Register indices.
`define HPSS_IDX_SLOT_STS 10'h05a
`define HPSS_IDX_DCAP2 10'h064
`define HPSS_IDX_DCTL2 10'h068
`define HPSS_IDX_DSTS2 10'h06a
`define HPSS_IDX_LCAP2 10'h06c
`define HPSS_IDX_LCTL2 10'h070
`define HPSS_IDX_SLOT_CTL 10'h080
`define HPSS_IDX_IRQ_STS 10'h081
`define HPSS_IDX_IRQ_CLR 10'h082
`define HPSS_IDX_IRQ_EN 10'h083
// Slot status field positions.
`define HPSS_B_BUTTON 0
`define HPSS_B_PFAULT 1
`define HPSS_B_LATCH_CHG 2
`define HPSS_B_PRES_CHG 3
`define HPSS_B_CMD_DONE 4
`define HPSS_B_LATCH 5
`define HPSS_B_PRESENT 6
`define HPSS_B_INTLK 7
`define HPSS_B_LINK_CHG 8
// Slot control field positions.
`define HPSS_C_MASTER 5
`define HPSS_C_INTLK 11
`define HPSS_C_LINK_EN 12
// Masks and reset values.
`define HPSS_STS_W1C 9'h11f
`define HPSS_CTL_WMASK 16'h17ff
`define HPSS_CTL_RST 16'h01c0
`define HPSS_PIN_RST 5'h08
`define HPSS_RSVD_VAL 32'h0000_0000
`define HPSS_EVT_RST 9'h000
`endif

// ---- design/hpss_pkg.sv ----
// Purpose: Types shared by the slot status bank.
// Assumes: Constants live in hpss_cfg.svh.
// Notes: Nothing here holds a value.
package hpss_pkg;
  typedef enum logic {CMD_IDLE, CMD_WAIT} hpss_cmd_st_t;
  typedef logic [8:0] hpss_evt_t;
  typedef logic [15:0] hpss_half_t;
endpackage : hpss_pkg

// ---- design/hpss_cmd_if.sv ----
// Purpose: Command hand-off between the register bank and the tracker.
// Assumes: One clock for both ends.
// Notes: issue and done are one-cycle pulses.
`timescale 1ns/1ps
interface hpss_cmd_if;
  logic issue;
  hpss_pkg::hpss_half_t word;
  logic done;
  modport bank (output issue, output word, input done);
  modport tracker (input issue, input word, output done);
endinterface : hpss_cmd_if

// ---- design/hpss_cmd_tracker.sv ----
// Purpose: Turns slot control writes into expander commands.
// Assumes: exp_cmd_done comes from same-clock expander logic.
// Notes: One further command may wait while one is in flight.
`timescale 1ns/1ps
`include "hpss_cfg.svh"
module hpss_cmd_tracker (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset.
  hpss_cmd_if.tracker cmd, // Command hand-off.
  output logic exp_cmd_start, // Start pulse to expander.
  output hpss_pkg::hpss_half_t exp_cmd_ctl, // Command word.
  input wire logic exp_cmd_done // Expander finished.
);
  hpss_pkg::hpss_cmd_st_t st, next_st;
  logic pend, next_pend, next_start, next_done;
  hpss_pkg::hpss_half_t pend_w, next_pend_w, next_ctl;

  // Next command state: done pulses at each expander completion, even with a command waiting.
  always_comb begin
    next_st = st;
    next_pend = pend;
    next_pend_w = pend_w;
    next_start = 1'b0;
    next_done = 1'b0;
    next_ctl = exp_cmd_ctl;
    unique case (st)
      hpss_pkg::CMD_IDLE: begin
        if (cmd.issue) begin
          next_start = 1'b1;
          next_ctl = cmd.word;
          next_st = hpss_pkg::CMD_WAIT;
        end
      end
      hpss_pkg::CMD_WAIT: begin
        if (exp_cmd_done) begin
          next_done = 1'b1;
          if (pend) begin
            next_start = 1'b1;
            next_ctl = pend_w;
            next_pend = cmd.issue;
            next_pend_w = cmd.word;
          end else if (cmd.issue) begin
            next_start = 1'b1;
            next_ctl = cmd.word;
          end else begin
            next_st = hpss_pkg::CMD_IDLE;
          end
        end else if (cmd.issue) begin
          next_pend = 1'b1;
          next_pend_w = cmd.word;
        end
      end
    endcase
  end

  // Registers the command state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= hpss_pkg::CMD_IDLE;
      pend <= 1'b0;
      pend_w <= 16'h0000;
      exp_cmd_start <= 1'b0;
      exp_cmd_ctl <= 16'h0000;
      cmd.done <= 1'b0;
    end else begin
      st <= next_st;
      pend <= next_pend;
      pend_w <= next_pend_w;
      exp_cmd_start <= next_start;
      exp_cmd_ctl <= next_ctl;
      cmd.done <= next_done;
    end
  end

  sequence idle_issue_s;
    st == hpss_pkg::CMD_IDLE && cmd.issue;
  endsequence
  sequence start_word_s;
    exp_cmd_start && exp_cmd_ctl == $past(cmd.word);
  endsequence

  one_start_a: assert property (@(posedge clk_sys) disable iff (rst)
    idle_issue_s |=> start_word_s)
    else $error("Write in idle did not start one command.");
  done_after_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd.done |-> $past(exp_cmd_done) && $past(st) == hpss_pkg::CMD_WAIT)
    else $error("Command done without expander completion.");
endmodule : hpss_cmd_tracker

// ---- design/hpss_slot_status.sv ----
// Purpose: Slot status register bank of a hot-plug port.
// Assumes: Avalon-MM byte address; slot pins are asynchronous.
// Notes: Reserved and unmapped words read zero, writes are dropped.
//
// Operation
// - Button press sets bit 0, write one clears.
// - Power fault sets bit 1, write one clears.
// - Latch sensor change sets bit 2.
// - Presence change sets bit 3.
// - Command completion sets sticky bit 4.
// - Each slot control write is one command; a write while one waits replaces it.
// - Done only after all expander transactions finish; done here pulses at each completion, even with a command waiting.
// - Bit 5 shows live latch state, resets 0.
// - Bit 6 shows card presence, resets 1.
// - Bit 7 shows live interlock status.
// - Link-active change sets bit 8.
// - Slot status at index 0x05A, 15:9 zero.
// - Indices 0x064 to 0x070 read zero.
// - Interrupt needs master and event enables.
`timescale 1ns/1ps
`include "hpss_cfg.svh"
module hpss_slot_status (
  input wire logic clk_sys, // 20 MHz system clock.
  input wire logic rst, // Synchronous reset, high.
  input wire logic [11:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte lanes.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Stall, high at idle.
  input wire logic pin_attention_button, // Button, high pressed.
  input wire logic pin_power_fault, // Fault, high active.
  input wire logic pin_latch_sensor, // High when latch open.
  input wire logic pin_card_present, // High with card.
  input wire logic pin_interlock, // High when engaged.
  input wire logic link_active_flag, // Link active level.
  output logic exp_cmd_start, // Expander command pulse.
  output logic [15:0] exp_cmd_ctl, // Expander command word.
  input wire logic exp_cmd_done, // Expander finished pulse.
  output logic irq // Interrupt level.
);
  // ************************************************************
  // Synchronisers and edge detection
  // ************************************************************
  logic [4:0] pins, pin_s1, pin_s2, pin_d;
  logic link_d;
  hpss_pkg::hpss_evt_t evt;
  hpss_cmd_if cmd ();

  assign pins = {pin_interlock, pin_card_present, pin_latch_sensor,
                 pin_power_fault, pin_attention_button};

  // Two-stage synchroniser, then a delayed copy for edges.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1 <= `HPSS_PIN_RST;
      pin_s2 <= `HPSS_PIN_RST;
      pin_d <= `HPSS_PIN_RST;
      link_d <= 1'b0;
    end else begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
      link_d <= link_active_flag;
    end
  end

  // Event pulses, one cycle each.
  always_comb begin
    evt = `HPSS_EVT_RST;
    evt[`HPSS_B_BUTTON] = pin_s2[0] & ~pin_d[0];
    evt[`HPSS_B_PFAULT] = pin_s2[1] & ~pin_d[1];
    evt[`HPSS_B_LATCH_CHG] = pin_s2[2] ^ pin_d[2];
    evt[`HPSS_B_PRES_CHG] = pin_s2[3] ^ pin_d[3];
    evt[`HPSS_B_CMD_DONE] = cmd.done;
    evt[`HPSS_B_LINK_CHG] = link_active_flag ^ link_d;
  end

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic [9:0] idx;
  logic wr, rd_start;
  logic [15:0] lane_m;
  logic [31:0] wd;

  // Writes take effect at the edge where waitrequest is low.
  assign idx = avs_address[11:2];
  assign wr = avs_write & ~avs_waitrequest;
  assign rd_start = avs_read & avs_waitrequest;
  assign wd = avs_writedata;
  assign lane_m = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // ************************************************************
  // Registers
  // ************************************************************
  hpss_pkg::hpss_evt_t flag, next_flag, sts_clr;
  hpss_pkg::hpss_evt_t isr, next_isr, isr_clr;
  hpss_pkg::hpss_evt_t ien, next_ien, gate;
  hpss_pkg::hpss_half_t ctl, next_ctl, ctl_wm, sts_word;
  logic next_irq;

  // Next register values; a set in the clear cycle wins.
  always_comb begin
    sts_clr = `HPSS_EVT_RST;
    isr_clr = `HPSS_EVT_RST;
    next_ien = ien;
    next_ctl = ctl;
    ctl_wm = lane_m & `HPSS_CTL_WMASK;
    cmd.issue = 1'b0;
    cmd.word = ctl;
    if (wr && idx == `HPSS_IDX_SLOT_STS) begin
      sts_clr = wd[8:0] & lane_m[8:0] & `HPSS_STS_W1C;
    end
    if (wr && idx == `HPSS_IDX_IRQ_CLR) begin
      isr_clr = wd[8:0] & lane_m[8:0];
    end
    if (wr && idx == `HPSS_IDX_IRQ_EN) begin
      next_ien = (ien & ~lane_m[8:0]) | (wd[8:0] & lane_m[8:0]);
    end
    if (wr && idx == `HPSS_IDX_SLOT_CTL) begin
      next_ctl = (ctl & ~ctl_wm) | (wd[15:0] & ctl_wm);
      cmd.issue = 1'b1;
      cmd.word = next_ctl;
      cmd.word[`HPSS_C_INTLK] = wd[`HPSS_C_INTLK] & avs_byteenable[1];
    end
    next_flag = ((flag & ~sts_clr) | evt) & `HPSS_STS_W1C;
    next_isr = ((isr & ~isr_clr) | evt) & `HPSS_STS_W1C;
    gate = {ctl[`HPSS_C_LINK_EN], 3'b000, ctl[4:0]}
           & {9{ctl[`HPSS_C_MASTER]}};
    next_irq = |(isr & ien & gate);
  end

  // Registers the bank state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag <= `HPSS_EVT_RST;
      isr <= `HPSS_EVT_RST;
      ien <= `HPSS_EVT_RST;
      ctl <= `HPSS_CTL_RST;
      irq <= 1'b0;
    end else begin
      flag <= next_flag;
      isr <= next_isr;
      ien <= next_ien;
      ctl <= next_ctl;
      irq <= next_irq;
    end
  end

  // ************************************************************
  // Read path and wait state
  // ************************************************************
  logic [31:0] next_rdata;
  logic next_wait;

  // Slot status word: live state bits between the flags.
  always_comb begin
    sts_word = 16'h0000;
    sts_word[4:0] = flag[4:0];
    sts_word[`HPSS_B_LATCH] = pin_s2[2];
    sts_word[`HPSS_B_PRESENT] = pin_s2[3];
    sts_word[`HPSS_B_INTLK] = pin_s2[4];
    sts_word[`HPSS_B_LINK_CHG] = flag[`HPSS_B_LINK_CHG];
  end

  // Read data is taken in the first request cycle.
  always_comb begin
    next_rdata = avs_readdata;
    next_wait = ~((avs_read | avs_write) & avs_waitrequest);
    if (rd_start) begin
      case (idx)
        `HPSS_IDX_SLOT_STS: next_rdata = {16'h0000, sts_word};
        `HPSS_IDX_SLOT_CTL: next_rdata = {16'h0000, ctl};
        `HPSS_IDX_IRQ_STS: next_rdata = {23'h000000, isr};
        `HPSS_IDX_IRQ_EN: next_rdata = {23'h000000, ien};
        `HPSS_IDX_DCAP2, `HPSS_IDX_DCTL2, `HPSS_IDX_DSTS2,
        `HPSS_IDX_LCAP2, `HPSS_IDX_LCTL2: begin
          next_rdata = `HPSS_RSVD_VAL;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Registers the bus answer.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      avs_readdata <= next_rdata;
      avs_waitrequest <= next_wait;
    end
  end

  // ************************************************************
  // Command tracker
  // ************************************************************
  hpss_cmd_tracker u_track (
    .clk_sys(clk_sys),
    .rst(rst),
    .cmd(cmd.tracker),
    .exp_cmd_start(exp_cmd_start),
    .exp_cmd_ctl(exp_cmd_ctl),
    .exp_cmd_done(exp_cmd_done)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence rd_sts_s;
    avs_read && avs_waitrequest && idx == `HPSS_IDX_SLOT_STS;
  endsequence
  sequence rd_rsvd_s;
    avs_read && avs_waitrequest && idx >= `HPSS_IDX_DCAP2
      && idx <= `HPSS_IDX_LCTL2;
  endsequence
  sequence no_clr_s(int b);
    !(wr && idx == `HPSS_IDX_SLOT_STS && wd[b] && lane_m[b]);
  endsequence

  button_flag_a: assert property (
    $rose(pin_s2[0]) |=> flag[`HPSS_B_BUTTON])
    else $error("Button press did not set its flag.");
  fault_flag_a: assert property (
    pin_s2[1] && !pin_d[1] |=> flag[`HPSS_B_PFAULT])
    else $error("Power fault did not set its flag.");
  latch_chg_a: assert property (
    pin_s2[2] != pin_d[2] |=> flag[`HPSS_B_LATCH_CHG])
    else $error("Latch change did not set its flag.");
  pres_chg_a: assert property (
    pin_s2[3] != pin_d[3] |=> flag[`HPSS_B_PRES_CHG])
    else $error("Presence change did not set its flag.");
  cmd_sticky_a: assert property (
    flag[`HPSS_B_CMD_DONE] and no_clr_s(4) |=> flag[`HPSS_B_CMD_DONE])
    else $error("Command done flag dropped without a clear.");
  link_chg_a: assert property (
    $changed(link_active_flag) |=> flag[`HPSS_B_LINK_CHG])
    else $error("Link-active change did not set its flag.");
  live_bits_a: assert property (
    rd_sts_s |=> avs_readdata[7:5] == $past(pin_s2[4:2])
      && !avs_waitrequest)
    else $error("Live state bits read wrong.");
  sts_upper_a: assert property (
    rd_sts_s |=> avs_readdata[31:9] == 23'h000000)
    else $error("Reserved slot status bits not zero.");
  rsvd_zero_a: assert property (
    rd_rsvd_s |=> avs_readdata == 32'h0000_0000)
    else $error("Reserved register read not zero.");
  irq_gate_a: assert property (
    !ctl[`HPSS_C_MASTER] |=> !irq)
    else $error("Interrupt raised with master enable off.");
  zero_write_a: assert property (
    flag[`HPSS_B_BUTTON] and no_clr_s(0) |=> flag[`HPSS_B_BUTTON])
    else $error("Flag lost without a write of one.");

  // ************************************************************
  // Bus and register checks
  // ************************************************************

  // Bus request in an idle cycle, and reads of other words.
  sequence req_idle_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence rd_ctl_s;
    avs_read && avs_waitrequest && idx == `HPSS_IDX_SLOT_CTL;
  endsequence
  sequence rd_free_s;
    avs_read && avs_waitrequest && idx > `HPSS_IDX_IRQ_EN;
  endsequence

  // A write of one to a flag, in a cycle with no new event.
  sequence clr_btn_s;
    wr && idx == `HPSS_IDX_SLOT_STS && wd[`HPSS_B_BUTTON]
      && lane_m[`HPSS_B_BUTTON] && !evt[`HPSS_B_BUTTON];
  endsequence
  sequence clr_link_s;
    wr && idx == `HPSS_IDX_SLOT_STS && wd[`HPSS_B_LINK_CHG]
      && lane_m[`HPSS_B_LINK_CHG] && !evt[`HPSS_B_LINK_CHG];
  endsequence
  sequence clr_isr_s;
    wr && idx == `HPSS_IDX_IRQ_CLR && wd[`HPSS_B_CMD_DONE]
      && lane_m[`HPSS_B_CMD_DONE] && !evt[`HPSS_B_CMD_DONE];
  endsequence

  // Every request waits exactly one cycle, and the answer lasts one.
  one_wait_a: assert property (
    req_idle_s |=> !avs_waitrequest)
    else $error("Bus request not answered after one wait cycle.");
  wait_back_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("Bus answer stood longer than one cycle.");

  // Control reads hide the toggle bit; unmapped words read zero.
  ctl_read_a: assert property (
    rd_ctl_s |=> avs_readdata[31:13] == 19'h00000
      && !avs_readdata[`HPSS_C_INTLK])
    else $error("Slot control read shows write-only bits.");
  free_zero_a: assert property (
    rd_free_s |=> avs_readdata == 32'h0000_0000)
    else $error("Unmapped register read not zero.");

  // A write of one clears a flag when no event meets it.
  btn_clear_a: assert property (
    clr_btn_s |=> !flag[`HPSS_B_BUTTON])
    else $error("Button flag not cleared by a write of one.");
  link_clear_a: assert property (
    clr_link_s |=> !flag[`HPSS_B_LINK_CHG])
    else $error("Link-active flag not cleared by a write of one.");
  isr_clear_a: assert property (
    clr_isr_s |=> !isr[`HPSS_B_CMD_DONE])
    else $error("Interrupt status not cleared by a write of one.");

  // A held power fault does not set its flag again.
  fault_level_a: assert property (
    pin_s2[1] && pin_d[1] && !flag[`HPSS_B_PFAULT] |=>
      !flag[`HPSS_B_PFAULT])
    else $error("Held power fault set its flag again.");

  // The command done flag rises only after the tracker's done pulse.
  done_rise_a: assert property (
    $rose(flag[`HPSS_B_CMD_DONE]) |-> $past(cmd.done))
    else $error("Command done flag set without a finished command.");

  // Control and enables move only when software writes them.
  ctl_hold_a: assert property (
    !(wr && idx == `HPSS_IDX_SLOT_CTL) |=> $stable(ctl))
    else $error("Slot control changed without a write.");
  ien_hold_a: assert property (
    !(wr && idx == `HPSS_IDX_IRQ_EN) |=> $stable(ien))
    else $error("Interrupt enables changed without a write.");

  // An enabled, latched completion raises the interrupt next cycle.
  irq_raise_a: assert property (
    isr[`HPSS_B_CMD_DONE] && ien[`HPSS_B_CMD_DONE]
      && ctl[`HPSS_B_CMD_DONE] && ctl[`HPSS_C_MASTER] |=> irq)
    else $error("Enabled completion did not raise the interrupt.");
endmodule : hpss_slot_status

// ---- test/hpss_exp_model.sv ----
// Purpose: Stand-in for the serial I/O expander behind the slot commands.
// Assumes: Same clock as the bank; one start gives one done pulse.
// Notes: The bench sets the latency, so answers can be prompt or slow.
`timescale 1ns/1ps
module hpss_exp_model (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic exp_cmd_start, // Command start pulse.
  input wire logic [15:0] exp_cmd_ctl, // Command word.
  input wire logic [3:0] lat, // Extra busy cycles.
  output logic exp_cmd_done, // Done pulse.
  output logic [15:0] last_ctl, // Last word taken.
  output int starts // Commands seen.
);
  int cnt;
  // Runs the transaction down, then pulses done once, never on the start.
  always_ff @(posedge clk_sys) begin
    exp_cmd_done <= 1'b0;
    if (rst) begin
      cnt <= 0;
      starts <= 0;
      last_ctl <= 16'h0000;
    end else if (exp_cmd_start) begin
      cnt <= int'(lat) + 2;
      starts <= starts + 1;
      last_ctl <= exp_cmd_ctl;
    end else if (cnt == 1) begin
      exp_cmd_done <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : hpss_exp_model

// ---- test/hot_plug_slot_status_bank_tb.sv ----
// Purpose: Self-checking bench of the slot status bank.
// Assumes: One wait cycle per bus access; expander model on the far side.
// Notes: Expected status is rebuilt from the pins the bench drives.
`timescale 1ns/1ps
`include "hpss_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("mismatch t=%0t got %h exp %h", $time, g, e); \
  end end
module hot_plug_slot_status_bank_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic btn = 1'b0, pf = 1'b0, lsen = 1'b0, pres = 1'b1, ilk = 1'b0;
  logic link = 1'b0;
  logic start, done, irq;
  logic [15:0] ctl, last_ctl;
  logic [3:0] lat = 4'h0;
  int starts, s0, fail_count = 0, total_checks = 0;
  logic [8:0] flags = 9'h000;
  logic [31:0] v, c;
  // ****************************************
  // Clock, design and expander model.
  // ****************************************
  always #25 clk_sys = ~clk_sys;
  hpss_slot_status uut (.clk_sys(clk_sys), .rst(rst), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .pin_attention_button(btn), .pin_power_fault(pf),
    .pin_latch_sensor(lsen), .pin_card_present(pres), .pin_interlock(ilk),
    .link_active_flag(link), .exp_cmd_start(start), .exp_cmd_ctl(ctl),
    .exp_cmd_done(done), .irq(irq));
  hpss_exp_model exp_m (.clk_sys(clk_sys), .rst(rst), .exp_cmd_start(start),
    .exp_cmd_ctl(ctl), .lat(lat), .exp_cmd_done(done), .last_ctl(last_ctl),
    .starts(starts));
  // Expected slot status word from sticky flags and live pins.
  function automatic logic [31:0] sts_exp();
    return {23'h0, flags[8], ilk, pres, lsen, flags[4:0]};
  endfunction : sts_exp
  // Word index of the i-th reserved second-generation register.
  function automatic logic [9:0] rsv_idx(input int i);
    case (i)
      0: return `HPSS_IDX_DCAP2;
      1: return `HPSS_IDX_DCTL2;
      2: return `HPSS_IDX_DSTS2;
      3: return `HPSS_IDX_LCAP2;
      default: return `HPSS_IDX_LCTL2;
    endcase
  endfunction : rsv_idx
  // One bus access, held until waitrequest is seen low at an edge.
  // A slave that never answers is cut short by the watchdog.
  task automatic bus(input logic w, input logic [9:0] idx,
    input logic [31:0] d, output logic [31:0] q);
    rd <= ~w;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= d;
    do begin
      @(posedge clk_sys);
    end while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0, v);
    `CHK(v, e)
  endtask : rd_chk
  // Waits for the expander to finish, then for the flag to land.
  task automatic wait_cmd();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (done !== 1'b1 && n < 100);
    repeat (3) @(posedge clk_sys);
    flags[4] = 1'b1;
    `CHK(n < 100, 1'b1)
  endtask : wait_cmd
  // Toggles one slot pin and records the event it should latch.
  task automatic hit(input int k);
    case (k)
      0: begin
        flags[0] = flags[0] | ~btn;
        btn <= ~btn;
      end
      1: begin
        flags[1] = flags[1] | ~pf;
        pf <= ~pf;
      end
      2: begin
        flags[2] = 1'b1;
        lsen <= ~lsen;
      end
      3: begin
        flags[3] = 1'b1;
        pres <= ~pres;
      end
      4: ilk <= ~ilk;
      default: begin
        flags[8] = 1'b1;
        link <= ~link;
      end
    endcase
    repeat (6) @(posedge clk_sys);
  endtask : hit
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  // Watchdog cuts a hang short.
  initial begin
    #2_000_000;
    fail_count++;
    wrap_up();
  end
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    void'($urandom(86311));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd_chk(`HPSS_IDX_SLOT_STS, 32'h0000_0040);
    rd_chk(`HPSS_IDX_SLOT_CTL, 32'h0000_01c0);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, rsv_idx(i), $urandom, v);
      rd_chk(rsv_idx(i), 32'h0);
    end
    rd_chk(10'h3ff, 32'h0);
    for (int k = 0; k < 12; k++) begin
      hit(k % 6);
      rd_chk(`HPSS_IDX_SLOT_STS, sts_exp());
    end
    bus(1'b1, `HPSS_IDX_SLOT_STS, 32'h0, v);
    rd_chk(`HPSS_IDX_SLOT_STS, sts_exp());
    for (int k = 0; k < 10; k++) begin
      hit(int'($urandom_range(5)));
      c = $urandom;
      bus(1'b1, `HPSS_IDX_SLOT_STS, c, v);
      flags = flags & ~(c[8:0] & 9'h11f);
      rd_chk(`HPSS_IDX_SLOT_STS, sts_exp());
    end
    bus(1'b1, `HPSS_IDX_SLOT_STS, 32'h0000_ffff, v);
    flags = 9'h000;
    lat <= 4'ha;
    bus(1'b1, `HPSS_IDX_SLOT_CTL, 32'h0000_0d5f, v);
    rd_chk(`HPSS_IDX_SLOT_STS, sts_exp());
    wait_cmd();
    rd_chk(`HPSS_IDX_SLOT_STS, sts_exp());
    for (int k = 0; k < 5; k++) begin
      lat <= 4'($urandom);
      c = $urandom & 32'h0000_ffdf;
      s0 = starts;
      bus(1'b1, `HPSS_IDX_SLOT_CTL, c, v);
      wait_cmd();
      `CHK(starts, s0 + 1)
      `CHK(last_ctl, c[15:0] & 16'h1fff)
      rd_chk(`HPSS_IDX_SLOT_STS, sts_exp());
    end
    lat <= 4'h0;
    bus(1'b1, `HPSS_IDX_IRQ_EN, 32'h0000_01ff, v);
    bus(1'b1, `HPSS_IDX_SLOT_CTL, 32'h0000_001f, v);
    wait_cmd();
    bus(1'b1, `HPSS_IDX_IRQ_CLR, 32'h0000_01ff, v);
    hit(5);
    `CHK(irq, 1'b0)
    bus(1'b1, `HPSS_IDX_SLOT_CTL, 32'h0000_003f, v);
    wait_cmd();
    `CHK(irq, 1'b1)
    bus(1'b1, `HPSS_IDX_IRQ_EN, 32'h0, v);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    bus(1'b1, `HPSS_IDX_IRQ_EN, 32'h0000_01ff, v);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    bus(1'b1, `HPSS_IDX_IRQ_CLR, 32'h0000_01ff, v);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    bus(1'b1, `HPSS_IDX_SLOT_CTL, 32'h0000_0020, v);
    wait_cmd();
    `CHK(irq, 1'b0)
    rd_chk(`HPSS_IDX_SLOT_STS, sts_exp());
    wrap_up();
  end
endmodule : hot_plug_slot_status_bank_tb
